//--- verilog/bfs_cfg.svh
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// Strap width and decoded codes
`define BFS_STRAP_W        3
`define BFS_SEL_W          2
`define BFS_CODE_INTERNAL  3'h7
`define BFS_CODE_EXTERNAL  3'h6

// Steering output values (bit1 = select1 path, bit0 = select0 path)
`define BFS_SEL_INTERNAL   2'h2
`define BFS_SEL_EXTERNAL   2'h1

// Reserved strap codes; each one steers like internal boot
`define BFS_CODE_RSV5      3'h5
`define BFS_CODE_RSV4      3'h4
`define BFS_CODE_RSV3      3'h3
`define BFS_CODE_RSV2      3'h2
`define BFS_CODE_RSV1      3'h1
`define BFS_CODE_RSV0      3'h0

// Synchroniser depth and the capture wait after reset release
`define BFS_SYNC_STAGES    3
`define BFS_FILL_ZERO      2'h0
`define BFS_FILL_STEP      2'h1
`define BFS_FILL_LAST      2'h2
`define BFS_EXT_RESET      1'h0

// Boot chip selects sharing one capacity budget
`define BFS_SEL_COUNT      2
`define BFS_CAP_ZERO       32'h0000_0000

// Flash capacity limits in bytes
`define BFS_DEV_BYTES      32'h0400_0000
`define BFS_TOTAL_BYTES    32'h0800_0000
`define BFS_DEV_ADDR_W     26

`endif

//--- verilog/bfs_pkg.sv
`default_nettype none
`include "bfs_cfg.svh"

package bfs_pkg;

  // Sampling phases of the decoder
  typedef enum logic [1:0] {
    BFS_ST_RESET,
    BFS_ST_SYNC,
    BFS_ST_HOLD
  } bfs_state_t;

  // Synchroniser stages for the strap pins
  typedef struct packed {
    logic [`BFS_STRAP_W-1:0] s1;
    logic [`BFS_STRAP_W-1:0] s2;
    logic [`BFS_STRAP_W-1:0] s3;
  } bfs_sync_t;

  // Whole decoder state
  typedef struct packed {
    bfs_state_t            state;
    logic [`BFS_SEL_W-1:0] sel;
    logic                  ext;
    logic [1:0]            agree_cnt;
  } bfs_top_t;

endpackage
`default_nettype wire

//--- verilog/bfs_strap_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "bfs_cfg.svh"

module bfs_strap_sync (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // Raw strap pins
  input  wire logic [`BFS_STRAP_W-1:0] strap_i,
  // Synchronised strap
  output logic      [`BFS_STRAP_W-1:0] strap_o,
  output logic                         stable_o
);

  bfs_pkg::bfs_sync_t sync_r;
  bfs_pkg::bfs_sync_t sync_nxt;

  // Shift chain; first stage feeds only the second
  always_comb begin
    sync_nxt    = sync_r;
    sync_nxt.s1 = strap_i;
    sync_nxt.s2 = sync_r.s1;
    sync_nxt.s3 = sync_r.s2;
  end

  // Reset to all-high, matching the module pull-ups
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_r <= {`BFS_SYNC_STAGES{`BFS_CODE_INTERNAL}};
    end else begin
      sync_r <= sync_nxt;
    end
  end

  // A change counts once stage two and three agree
  assign strap_o  = sync_r.s3;
  assign stable_o = (sync_r.s2 == sync_r.s3);

endmodule
`default_nettype wire

//--- verilog/bfs_boot_flash_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "bfs_cfg.svh"

module bfs_boot_flash_select (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // Strap pins from the carrier
  input  wire logic [`BFS_STRAP_W-1:0] boot_source_strap_i,
  // Steering output to chip-select multiplexer
  output logic      [`BFS_SEL_W-1:0]   boot_flash_sel_o,
  // Status
  output logic                         external_boot_o,
  output logic                         strap_latched_o,
  // Capacity limits
  output logic      [31:0]             flash_dev_bytes_o,
  output logic      [31:0]             flash_total_bytes_o
);

  // Captured decoder state
  bfs_pkg::bfs_top_t          top_r;
  bfs_pkg::bfs_top_t          top_nxt;

  // Synchronised strap and its agreement flag
  logic [`BFS_STRAP_W-1:0]    strap_sync;
  logic                       strap_stable;

  // Decode results for the strap as it stands now
  logic                       fill_done;
  logic [`BFS_SEL_W-1:0]      sel_decoded;
  logic                       ext_decoded;

  // Capacity bookkeeping across the boot chip selects
  logic [31:0]                sel_cap_bytes [`BFS_SEL_COUNT];
  logic [31:0]                cap_sum       [`BFS_SEL_COUNT+1];
  logic [31:0]                total_cap;

  // Strap decode table; any code not listed as external keeps the module flash first
  function automatic logic [`BFS_SEL_W-1:0] decode_sel(input logic [`BFS_STRAP_W-1:0] code);
    begin
      // Safe value should an unknown code ever reach the table
      decode_sel = `BFS_SEL_INTERNAL;
      case (code)
        `BFS_CODE_INTERNAL: begin
          decode_sel = `BFS_SEL_INTERNAL;
        end

        // only the lowest line tied low
        `BFS_CODE_EXTERNAL: begin
          decode_sel = `BFS_SEL_EXTERNAL;
        end

        `BFS_CODE_RSV5: begin
          decode_sel = `BFS_SEL_INTERNAL;
        end

        // reserved, two lower lines tied low
        `BFS_CODE_RSV4: begin
          decode_sel = `BFS_SEL_INTERNAL;
        end

        `BFS_CODE_RSV3: begin
          decode_sel = `BFS_SEL_INTERNAL;
        end

        `BFS_CODE_RSV2: begin
          decode_sel = `BFS_SEL_INTERNAL;
        end

        // reserved, two upper lines tied low
        `BFS_CODE_RSV1: begin
          decode_sel = `BFS_SEL_INTERNAL;
        end

        `BFS_CODE_RSV0: begin
          decode_sel = `BFS_SEL_INTERNAL;
        end
      endcase
    end
  endfunction

  // strap pins pass three flops before use
  bfs_strap_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .strap_i   (boot_source_strap_i),
    .strap_o   (strap_sync),
    .stable_o  (strap_stable)
  );

  // Chain holds real pin values one edge after the fill counter reaches its end, when the state enters BFS_ST_SYNC
  assign fill_done   = (top_r.agree_cnt == `BFS_FILL_LAST);

  // decoded steering; external flag follows the same decode
  assign sel_decoded = decode_sel(strap_sync);
  assign ext_decoded = (sel_decoded == `BFS_SEL_EXTERNAL);

  // running sum of the storage behind each boot chip select
  assign cap_sum[0] = `BFS_CAP_ZERO;
  for (genvar gi = 0; gi < `BFS_SEL_COUNT; gi++) begin : g_cap
    // one device of fixed size per select
    assign sel_cap_bytes[gi] = `BFS_DEV_BYTES;
    assign cap_sum[gi+1]     = cap_sum[gi] + sel_cap_bytes[gi];
  end

  // never report more than the shared limit, whatever the select count
  assign total_cap = (cap_sum[`BFS_SEL_COUNT] > `BFS_TOTAL_BYTES) ? `BFS_TOTAL_BYTES
                                                                   : cap_sum[`BFS_SEL_COUNT];

  // Wait for the chain to fill with real pin values, then latch once
  always_comb begin
    top_nxt = top_r;
    unique case (top_r.state)
      // Flush the reset value out of the synchroniser
      bfs_pkg::BFS_ST_RESET: begin
        top_nxt.agree_cnt = top_r.agree_cnt + `BFS_FILL_STEP;
        if (fill_done) begin
          top_nxt.state = bfs_pkg::BFS_ST_SYNC;
        end
      end

      // A toggling strap only delays the capture, it never skips it
      bfs_pkg::BFS_ST_SYNC: begin
        if (strap_stable) begin
          top_nxt.sel   = sel_decoded;
          top_nxt.ext   = ext_decoded;
          top_nxt.state = bfs_pkg::BFS_ST_HOLD;
        end
      end

      // Late strap changes are ignored so the flash mapping cannot move mid-boot
      bfs_pkg::BFS_ST_HOLD: begin
        top_nxt = top_r;
      end

      // Unused state code: restart the capture with internal steering
      default: begin
        top_nxt.state     = bfs_pkg::BFS_ST_RESET;
        top_nxt.sel       = `BFS_SEL_INTERNAL;
        top_nxt.ext       = `BFS_EXT_RESET;
        top_nxt.agree_cnt = `BFS_FILL_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      top_r.state     <= bfs_pkg::BFS_ST_RESET;
      top_r.sel       <= `BFS_SEL_INTERNAL;
      top_r.ext       <= `BFS_EXT_RESET;
      top_r.agree_cnt <= `BFS_FILL_ZERO;
    end else begin
      top_r <= top_nxt;
    end
  end

  // Steering and external flag straight from flops; latched flag decoded from the state flops
  assign boot_flash_sel_o = top_r.sel;
  assign external_boot_o  = top_r.ext;
  assign strap_latched_o  = (top_r.state == bfs_pkg::BFS_ST_HOLD);

  assign flash_dev_bytes_o   = `BFS_DEV_BYTES;
  assign flash_total_bytes_o = total_cap;

endmodule
`default_nettype wire

//--- verif/bfs_carrier_model.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_carrier_model (
  // Lines the carrier ties low
  input  wire logic [2:0] tie_low_i,
  // Strap seen at the module
  output logic      [2:0] strap_o
);
  assign strap_o = ~tie_low_i;
endmodule
`default_nettype wire

//--- verif/bfs_sel_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_sel_sva (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // Watched ports
  input wire logic [2:0]  boot_source_strap_i,
  input wire logic [1:0]  boot_flash_sel_o,
  input wire logic        external_boot_o,
  input wire logic        strap_latched_o,
  input wire logic [31:0] flash_dev_bytes_o,
  input wire logic [31:0] flash_total_bytes_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Capture takes four edges after release
  sequence wait_s;
    !strap_latched_o [*4];
  endsequence
  chk_latch_time: assert property ($rose(rst_n_i) |-> wait_s ##1 strap_latched_o)
    else $error("latch time");
  chk_ext_code: assert property ($rose(strap_latched_o) |->
    external_boot_o == ($past(boot_source_strap_i, 4) == 3'h6))
    else $error("ext code");
  chk_sel_unlatched: assert property (!strap_latched_o |-> boot_flash_sel_o == 2'h2)
    else $error("sel unlatched");
  chk_ext_unlatched: assert property (!strap_latched_o |-> !external_boot_o)
    else $error("ext unlatched");
  chk_sel_ext: assert property (external_boot_o |-> boot_flash_sel_o == 2'h1)
    else $error("sel ext");
  chk_sel_int: assert property (!external_boot_o |-> boot_flash_sel_o == 2'h2)
    else $error("sel int");
  chk_sel_hold: assert property (strap_latched_o |=> strap_latched_o && $stable(boot_flash_sel_o))
    else $error("sel hold");
  chk_dev_bytes: assert property (flash_dev_bytes_o == 32'h0400_0000)
    else $error("dev bytes");
  chk_total_bytes: assert property (flash_total_bytes_o == 32'h0800_0000)
    else $error("total bytes");
endmodule
bind bfs_boot_flash_select bfs_sel_sva u_bfs_sel_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .boot_source_strap_i(boot_source_strap_i), .boot_flash_sel_o(boot_flash_sel_o),
  .external_boot_o(external_boot_o), .strap_latched_o(strap_latched_o),
  .flash_dev_bytes_o(flash_dev_bytes_o), .flash_total_bytes_o(flash_total_bytes_o));
`default_nettype wire

//--- verif/bfs_boot_flash_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_boot_flash_select_tb;
  logic        sys_clk_i = 1'h0;
  logic        rst_n_i   = 1'h0;
  logic [2:0]  tie_low   = 3'h0;
  logic [2:0]  strap;
  logic [1:0]  sel;
  logic        ext;
  logic        latched;
  logic [31:0] dev_bytes;
  logic [31:0] total_bytes;
  int         err_total = 0;
  int         num_checks = 0;
  int         cyc = 0;
  // Clock and cycle count for the hang limit
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      wrap_up();
    end
  end
  bfs_carrier_model u_bfs_carrier_model (.tie_low_i(tie_low), .strap_o(strap));
  bfs_boot_flash_select u_bfs_boot_flash_select (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .boot_source_strap_i(strap), .boot_flash_sel_o(sel), .external_boot_o(ext),
    .strap_latched_o(latched), .flash_dev_bytes_o(dev_bytes),
    .flash_total_bytes_o(total_bytes));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Every strap code, then a late strap change that must be ignored
  initial begin
    int code;
    int exp_sel;
    int exp_q[$];
    code = $urandom(32'h0000_a2de);
    for (code = 0; code < 8; code++) begin
      @(posedge sys_clk_i) #1;
      rst_n_i = 1'h0;
      tie_low = ~code[2:0];
      // Model: only code 6 steers boot to the carrier flash
      exp_q.push_back((code == 6) ? 2 - 1 : 2);
      repeat (3) @(posedge sys_clk_i);
      #1 chk("sel_rst", 32'h0000_0002, sel);
      chk("latched_rst", 32'h0000_0000, latched);
      chk("ext_rst", 32'h0000_0000, ext);
      rst_n_i = 1'h1;
      repeat (3) @(posedge sys_clk_i);
      #1 chk("latched_early", 32'h0000_0000, latched);
      @(posedge sys_clk_i);
      #1 exp_sel = exp_q.pop_front();
      chk("latched", 32'h0000_0001, latched);
      chk("sel", exp_sel, sel);
      chk("ext", (code == 6) ? 32'h0000_0001 : 32'h0000_0000, ext);
      chk("dev_bytes", 32'h0400_0000, dev_bytes);
      chk("total_bytes", 32'h0800_0000, total_bytes);
      tie_low = 3'($urandom);
      repeat (5) @(posedge sys_clk_i);
      #1 chk("sel_held", exp_sel, sel);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
